// *** core/fnts_pkg.sv ***
package fnts_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_LINK = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_CFG3 = 8'h28;
    localparam logic [7:0] OFS_TSEL = 8'h2C;
    // ==========================================================
    // Field positions
    localparam int BIT_LINK = 0;
    localparam int BIT_NMI_PIN = 4;
    localparam int BIT_OSC = 3;
    localparam int BIT_FLASH = 2;
    localparam int BIT_RAM_SE = 1;
    localparam int BIT_RAM_DE = 0;
    localparam int NUM_SRC = 5;
    localparam int ADDR_LSB = 18;
    localparam int ADDR_MSB = 31;
    localparam int POS_LSB = 12;
    localparam int POS_MSB = 17;
    localparam int TRIG_A_LSB = 30;
    localparam int TRIG_B_LSB = 28;
    localparam int TRIG_C_LSB = 24;
    localparam int TRIG_D_LSB = 22;
    localparam int BRK_A_LSB = 18;
    localparam int BRK_B_LSB = 14;
    localparam int BRK_C_LSB = 6;
    localparam int BRK_D_LSB = 2;
    localparam int BIT_COMP_SEL = 0;
    // ==========================================================
    // Reset values and masks
    localparam logic [31:0] RST_STATUS = 32'h00000000;
    localparam logic [4:0] RST_EN = 5'h0F;
    localparam logic [31:0] RST_TSEL = 32'h00000000;
    localparam logic [31:0] TSEL_MASK = 32'hF3FFC3FD;
    localparam logic [1:0] TRIG_RSVD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/fnts_reg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface fnts_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wr_mask;
    logic wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    modport slave(output wr_en, wr_addr, wr_data, wr_mask, rd_addr,
        input wr_hit, rd_data, rd_hit);
    modport regs(input wr_en, wr_addr, wr_data, wr_mask, rd_addr,
        output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// *** core/fnts_axil_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
module fnts_axil_slave
    import fnts_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    fnts_reg_if.slave rb
);
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] strb_q;
    logic do_wr;

    // Both halves held and no response pending
    assign do_wr = !awready && !wready && !bvalid;
    assign rb.wr_en = do_wr;
    assign rb.wr_addr = aw_q;
    assign rb.wr_data = w_q;
    assign rb.rd_addr = araddr;
    generate
        for (genvar i = 0; i < 4; i++) begin : g_mask
            assign rb.wr_mask[8*i+:8] = {8{strb_q[i]}};
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready <= 1'b1;
            aw_q <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_q <= awaddr;
        end else if (do_wr) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wready <= 1'b1;
            w_q <= 32'h00000000;
            strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_q <= wdata;
            strb_q <= wstrb;
        end else if (do_wr) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read data sampled at the address handshake
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rb.rd_data;
            rresp <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** core/fnts_timer_route.sv ***
`timescale 1ns/10ps
`default_nettype none
module fnts_timer_route
    import fnts_pkg::*;
#(
    parameter int NUM_TIMER = 4,
    parameter int NUM_BRK = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Selections
    input wire logic [2*NUM_TIMER-1:0] trig_sel,
    input wire logic [NUM_BRK-1:0] brk_sel,
    input wire logic lock_break,
    input wire logic comp_sel,
    // Sources
    input wire logic [2:0] ext_trigger,
    input wire logic [NUM_BRK-1:0] gpio_break,
    input wire logic [NUM_BRK-1:0] trigger_selection_unit_break,
    input wire logic a_ch0_in,
    input wire logic b_ch0_in,
    input wire logic b_ch0n_in,
    // Routed outputs
    output logic [NUM_TIMER-1:0] trig_out,
    output logic [NUM_BRK-1:0] brk_out,
    output logic comp_out
);
    generate
        for (genvar t = 0; t < NUM_TIMER; t++) begin : g_trig
            wire logic [1:0] code = trig_sel[2*t+:2];
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    trig_out[t] <= 1'b0;
                end else begin
                    // Reserved code drives a quiet low
                    trig_out[t] <= (code == TRIG_RSVD) ? 1'b0 :
                        ext_trigger[code];
                end
            end
        end
        for (genvar b = 0; b < NUM_BRK; b++) begin : g_brk
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    brk_out[b] <= 1'b0;
                end else begin
                    brk_out[b] <= (brk_sel[b] ? trigger_selection_unit_break[b] :
                        gpio_break[b]) | lock_break;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            comp_out <= 1'b0;
        end else begin
            comp_out <= comp_sel ? (b_ch0_in ^ b_ch0n_in ^ a_ch0_in) :
                b_ch0n_in;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_trig_reserved: assert property (
        (trig_sel[1:0] == TRIG_RSVD) |=> !trig_out[0])
        else $error("reserved trigger code let a trigger through");
    a_comp_xor: assert property (
        comp_sel |=> comp_out == $past(b_ch0_in ^ b_ch0n_in ^ a_ch0_in))
        else $error("complementary input xor wrong");
endmodule
`default_nettype wire

// *** core/fnts_top.sv ***
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fnts_top
    import fnts_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fault sources
    input wire logic nmi_pin,
    input wire logic osc_monitor_fault,
    input wire logic program_store_ecc_err,
    input wire logic ram_single_err,
    input wire logic ram_double_err,
    input wire logic [15:0] ram_err_addr,
    input wire logic [4:0] ram_err_bit,
    input wire logic core_lockup,
    // Timer sources
    input wire logic [2:0] ext_trigger,
    input wire logic [15:0] gpio_break,
    input wire logic [15:0] trigger_selection_unit_break,
    input wire logic adv_timer_a_ch0_in,
    input wire logic adv_timer_b_ch0_in,
    input wire logic adv_timer_b_ch0n_in,
    // Outputs
    output logic nmi_request,
    output logic [3:0] adv_trigger,
    output logic [15:0] adv_break,
    output logic adv_timer_b_comp_in
);
    // ==========================================================
    // Register state
    logic core_hang_break_link;
    logic [NUM_SRC-1:0] flag;
    logic [NUM_SRC-1:0] nmi_en;
    logic [ADDR_MSB-ADDR_LSB:0] ram_fault_word_addr;
    logic [POS_MSB-POS_LSB:0] ram_corrected_bit_pos;
    logic [31:0] timer_input_source_select;
    logic [NUM_SRC-1:0] event_in;
    logic [NUM_SRC-1:0] clr;
    logic [31:0] wr_bits;
    logic [7:0] trig_sel;
    logic [15:0] brk_sel;

    fnts_reg_if rb();

    // Word address of a byte address
    function automatic logic [7:0] word_of(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = word_of(a);
        return (w == OFS_LINK) || (w == OFS_STATUS) ||
            (w == OFS_CFG3) || (w == OFS_TSEL);
    endfunction

    function automatic logic wr_to(input logic [7:0] ofs);
        return rb.wr_en && (word_of(rb.wr_addr) == ofs);
    endfunction

    // ==========================================================
    // Bus slave
    fnts_axil_slave u_slave (
        .clock(clock),
        .resetn(resetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb.slave)
    );

    assign rb.wr_hit = is_mapped(rb.wr_addr);
    assign rb.rd_hit = is_mapped(rb.rd_addr);
    assign wr_bits = rb.wr_data & rb.wr_mask;

    // ==========================================================
    // Fault flags
    assign event_in = {nmi_pin, osc_monitor_fault, program_store_ecc_err,
        ram_single_err, ram_double_err};
    assign clr = wr_to(OFS_STATUS) ? wr_bits[NUM_SRC-1:0] : '0;

    // Pin flag mirrors the pin; software cannot clear it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag[BIT_NMI_PIN] <= RST_STATUS[BIT_NMI_PIN];
        end else begin
            flag[BIT_NMI_PIN] <= nmi_pin;
        end
    end

    // Sticky flags: an event in the clearing cycle survives
    generate
        for (genvar i = 0; i < BIT_NMI_PIN; i++) begin : g_flag
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    flag[i] <= RST_STATUS[i];
                end else begin
                    flag[i] <= event_in[i] | (flag[i] & ~clr[i]);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Enables, lockup link, timer selections
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            nmi_en <= RST_EN;
        end else if (wr_to(OFS_CFG3)) begin
            nmi_en <= (rb.wr_data[NUM_SRC-1:0] & rb.wr_mask[NUM_SRC-1:0]) |
                (nmi_en & ~rb.wr_mask[NUM_SRC-1:0]);
        end
    end

    // Set-only: a zero write cannot drop the link
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            core_hang_break_link <= 1'b0;
        end else if (wr_to(OFS_LINK) && wr_bits[BIT_LINK]) begin
            core_hang_break_link <= 1'b1;
        end
    end

    // Reserved bits are dropped, so they always read back zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_input_source_select <= RST_TSEL;
        end else if (wr_to(OFS_TSEL)) begin
            timer_input_source_select <= ((rb.wr_data & rb.wr_mask) |
                (timer_input_source_select & ~rb.wr_mask)) & TSEL_MASK;
        end
    end

    // ==========================================================
    // RAM ECC capture, latest event wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ram_fault_word_addr <= '0;
        end else if (ram_single_err || ram_double_err) begin
            ram_fault_word_addr <= ram_err_addr[15:2];
        end
    end

    // Double error leaves no correctable bit, so position reads zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ram_corrected_bit_pos <= '0;
        end else if (ram_double_err) begin
            ram_corrected_bit_pos <= '0;
        end else if (ram_single_err) begin
            ram_corrected_bit_pos <= 6'({1'b0, ram_err_bit}) + 6'h01;
        end
    end

    // ==========================================================
    // Interrupt request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            nmi_request <= 1'b0;
        end else begin
            nmi_request <= |(flag & nmi_en);
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rb.rd_data = 32'h00000000;
        case (word_of(rb.rd_addr))
            OFS_LINK: rb.rd_data[BIT_LINK] = core_hang_break_link;
            OFS_STATUS: rb.rd_data[NUM_SRC-1:0] = flag;
            OFS_CFG3: begin
                rb.rd_data[ADDR_MSB:ADDR_LSB] = ram_fault_word_addr;
                rb.rd_data[POS_MSB:POS_LSB] = ram_corrected_bit_pos;
                rb.rd_data[NUM_SRC-1:0] = nmi_en;
            end
            OFS_TSEL: rb.rd_data = timer_input_source_select;
            default: rb.rd_data = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Timer input routing
    // Break 0 of each timer sits at the top of its nibble
    always_comb begin
        trig_sel = {
            timer_input_source_select[TRIG_D_LSB+:2],
            timer_input_source_select[TRIG_C_LSB+:2],
            timer_input_source_select[TRIG_B_LSB+:2],
            timer_input_source_select[TRIG_A_LSB+:2]};
        brk_sel = {
            timer_input_source_select[BRK_A_LSB+:4],
            timer_input_source_select[BRK_B_LSB+:4],
            timer_input_source_select[BRK_C_LSB+:4],
            timer_input_source_select[BRK_D_LSB+:4]};
    end

    fnts_timer_route u_route (
        .clock(clock),
        .resetn(resetn),
        .trig_sel(trig_sel),
        .brk_sel(brk_sel),
        .lock_break(core_hang_break_link & core_lockup),
        .comp_sel(timer_input_source_select[BIT_COMP_SEL]),
        .ext_trigger(ext_trigger),
        .gpio_break(gpio_break),
        .trigger_selection_unit_break(trigger_selection_unit_break),
        .a_ch0_in(adv_timer_a_ch0_in),
        .b_ch0_in(adv_timer_b_ch0_in),
        .b_ch0n_in(adv_timer_b_ch0n_in),
        .trig_out(adv_trigger),
        .brk_out(adv_break),
        .comp_out(adv_timer_b_comp_in)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_link_sticky: assert property (
        core_hang_break_link |=> core_hang_break_link)
        else $error("lockup link dropped without reset");
    a_lock_break: assert property (
        core_hang_break_link && core_lockup |=> adv_break == 16'hFFFF)
        else $error("lockup did not reach every break input");
    a_unlock_break: assert property (
        !core_hang_break_link && brk_sel == 16'h0000
        |=> adv_break == $past(gpio_break))
        else $error("lockup leaked into breaks while unlinked");
    a_pin_flag: assert property (
        ##1 flag[BIT_NMI_PIN] == $past(nmi_pin))
        else $error("pin flag does not follow pin");
    a_set_wins: assert property (
        event_in[3:0] != 4'h0
        |=> (flag[3:0] & $past(event_in[3:0])) == $past(event_in[3:0]))
        else $error("event lost to a clear");
    a_w1c_clear: assert property (
        (clr[3:0] & ~event_in[3:0]) != 4'h0
        |=> (flag[3:0] & $past(clr[3:0] & ~event_in[3:0])) == 4'h0)
        else $error("write one did not clear flag");
    a_flag_hold: assert property (
        event_in[3:0] == 4'h0 && clr == '0 |=> $stable(flag[3:0]))
        else $error("flag changed with no cause");
    a_double_nmi: assert property (
        ram_double_err && nmi_en[BIT_RAM_DE] |=> ##1 nmi_request)
        else $error("double error raised no request");
    a_nmi_gated: assert property (
        nmi_en == '0 |=> !nmi_request)
        else $error("request with all enables off");
    a_addr_capture: assert property (
        ram_single_err || ram_double_err
        |=> ram_fault_word_addr == $past(ram_err_addr[15:2]))
        else $error("fault address not captured");
    a_bit_position: assert property (
        ram_single_err && !ram_double_err
        |=> ram_corrected_bit_pos == 6'($past(ram_err_bit)) + 6'h01)
        else $error("corrected bit position wrong");

    // ==========================================================
    // Checks on request gating, bit position and routing
    a_pin_gated: assert property (
        flag[BIT_NMI_PIN] && !nmi_en[BIT_NMI_PIN] &&
        (flag[3:0] & nmi_en[3:0]) == 4'h0 |=> !nmi_request)
        else $error("pin flag raised a request while disabled");
    a_nmi_any: assert property (
        (flag & nmi_en) != '0 |=> nmi_request)
        else $error("enabled flag raised no request");
    a_pos_double: assert property (
        ram_double_err |=> ram_corrected_bit_pos == '0)
        else $error("double error left a bit position");
    a_break_route: assert property (
        !core_hang_break_link |=> adv_break[15] ==
        $past(timer_input_source_select[BRK_A_LSB+3] ?
        trigger_selection_unit_break[15] : gpio_break[15]))
        else $error("first break input took the wrong source");
    a_trig_route: assert property (
        timer_input_source_select[TRIG_A_LSB+:2] != TRIG_RSVD
        |=> adv_trigger[0] ==
        $past(ext_trigger[timer_input_source_select[TRIG_A_LSB+:2]]))
        else $error("first trigger took the wrong source");

    c_clear_flag: cover property (clr != '0 && flag != '0);
    c_lock_break: cover property (core_hang_break_link && core_lockup);
    c_double_nmi: cover property (ram_double_err ##2 nmi_request);
    c_tsel_write: cover property (wr_to(OFS_TSEL));
    c_pin_nmi: cover property (flag[BIT_NMI_PIN] ##1 nmi_request);
endmodule
`default_nettype wire

// *** bench/test_fnts_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_fnts_top
    import fnts_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [3:0] ev = 4'h0;
    logic nmi_pin = 1'b0, core_lockup = 1'b0;
    logic ch_a = 1'b1, ch_b = 1'b0, ch_bn = 1'b0;
    logic [2:0] ext = 3'h5;
    logic [15:0] gpio = 16'hA5A5, tsb = 16'h5A5A, ram_addr = 16'h0;
    logic [4:0] ram_bit = 5'h00;
    logic awready, wready, bvalid, arready, rvalid, nmi_request, comp;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] trig;
    logic [15:0] brk;
    int mismatches = 0;
    int n_compared = 0;

    fnts_top fnts_top_inst (
        .clock(clock), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .nmi_pin(nmi_pin), .osc_monitor_fault(ev[3]),
        .program_store_ecc_err(ev[2]), .ram_single_err(ev[1]),
        .ram_double_err(ev[0]), .ram_err_addr(ram_addr),
        .ram_err_bit(ram_bit), .core_lockup(core_lockup),
        .ext_trigger(ext), .gpio_break(gpio), .trigger_selection_unit_break(tsb),
        .adv_timer_a_ch0_in(ch_a), .adv_timer_b_ch0_in(ch_b),
        .adv_timer_b_ch0n_in(ch_bn), .nmi_request(nmi_request),
        .adv_trigger(trig), .adv_break(brk), .adv_timer_b_comp_in(comp)
    );

    initial begin
        forever #25 clock = ~clock;
    end

    // ==========================================================
    // Bus and helper tasks
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic do_reset(input int n);
        resetn <= 1'b0;
        tick(n);
        resetn <= 1'b1;
        tick(1);
    endtask

    // Address and data held until each is taken on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bready <= 1'b0;
                `CHK(bresp, er)
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rready <= 1'b0;
                `CHK(rdata, ed)
                `CHK(rresp, er)
                break;
            end
        end
    endtask

    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        tick(1);
        ev[b] <= 1'b0;
    endtask

    // Hang guard: the whole sequence needs a few hundred cycles
    initial begin
        #1000000;
        mismatches++;
        stop_test;
    end

    // ==========================================================
    // Test sequence
    initial begin
        do_reset(20);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(OFS_CFG3, 32'h0000000F, RESP_OKAY);
        rd(OFS_TSEL, 32'h0, RESP_OKAY);
        rd(OFS_LINK, 32'h0, RESP_OKAY);
        rd(8'h04, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        $display("test reset_and_map done");
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            tick(2);
            `CHK(nmi_request, 1'b1)
            wr(OFS_STATUS, 32'h0, RESP_OKAY);
            rd(OFS_STATUS, 32'h1 << b, RESP_OKAY);
            wr(OFS_STATUS, 32'h1 << b, RESP_OKAY);
            rd(OFS_STATUS, 32'h0, RESP_OKAY);
            tick(2);
            `CHK(nmi_request, 1'b0)
        end
        wr(OFS_CFG3, 32'h0, RESP_OKAY);
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            tick(2);
            `CHK(nmi_request, 1'b0)
        end
        rd(OFS_STATUS, 32'h0000000F, RESP_OKAY);
        wr(OFS_CFG3, 32'h1, RESP_OKAY);
        tick(2);
        `CHK(nmi_request, 1'b1)
        wr(OFS_STATUS, 32'h0000000F, RESP_OKAY);
        $display("test sticky_flags done");
        nmi_pin <= 1'b1;
        tick(3);
        rd(OFS_STATUS, 32'h00000010, RESP_OKAY);
        `CHK(nmi_request, 1'b0)
        wr(OFS_CFG3, 32'h00000010, RESP_OKAY);
        tick(2);
        `CHK(nmi_request, 1'b1)
        nmi_pin <= 1'b0;
        tick(3);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        `CHK(nmi_request, 1'b0)
        $display("test nmi_pin done");
        ram_addr <= 16'hABCD;
        ram_bit <= 5'h1F;
        pulse(1);
        rd(OFS_CFG3, {14'h2AF3, 6'h20, 12'h010}, RESP_OKAY);
        ram_addr <= 16'h1234;
        pulse(0);
        rd(OFS_CFG3, {14'h048D, 6'h00, 12'h010}, RESP_OKAY);
        wr(OFS_STATUS, 32'h0000000F, RESP_OKAY);
        $display("test ecc_capture done");
        for (int c = 0; c < 4; c++) begin
            wr(OFS_TSEL, {c[1:0], c[1:0], 2'h0, c[1:0], c[1:0], 22'h0},
                RESP_OKAY);
            tick(3);
            `CHK(trig, {4{(c == 3) ? 1'b0 : ext[c]}})
        end
        wr(OFS_TSEL, 32'h0, RESP_OKAY);
        tick(3);
        `CHK(brk, gpio)
        `CHK(comp, ch_bn)
        wr(OFS_TSEL, 32'h003FC3FD, RESP_OKAY);
        rd(OFS_TSEL, 32'h003FC3FD, RESP_OKAY);
        tick(3);
        `CHK(brk, tsb)
        `CHK(comp, ch_a ^ ch_b ^ ch_bn)
        wr(OFS_TSEL, 32'h00200004, RESP_OKAY);
        tick(3);
        `CHK(brk, 16'h25A4)
        $display("test timer_select done");
        wr(OFS_TSEL, 32'h0, RESP_OKAY);
        core_lockup <= 1'b1;
        tick(3);
        `CHK(brk, gpio)
        wr(OFS_LINK, 32'h1, RESP_OKAY);
        tick(3);
        `CHK(brk, 16'hFFFF)
        wr(OFS_LINK, 32'h0, RESP_OKAY);
        rd(OFS_LINK, 32'h1, RESP_OKAY);
        do_reset(2);
        rd(OFS_LINK, 32'h0, RESP_OKAY);
        tick(2);
        `CHK(brk, gpio)
        $display("test lockup_link done");
        stop_test;
    end
endmodule
`default_nettype wire
